// [rtl/data_space_decoder.sv]
// Data space decoder and access sequencer top level.
`timescale 1ns/1ns
`include "dsd_regs.svh"
module data_space_decoder #(
   parameter int WRITE_CYCLES = `DSD_EE_WRITE_NS / `DSD_CLK_NS
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic arst_n,
   // Configuration.
   input wire logic legacyMode,
   input wire logic extSramEnableBit,
   input wire logic [1:0] waitStates,
   // Load/store request.
   input dsd_pkg::dsd_req_t req,
   output logic reqReady,
   output logic cpuStall,
   output logic accessDone,
   output logic [15:0] effAddr,
   output dsd_pkg::dsd_region_t region,
   output logic accessFault,
   output logic [15:0] ptrNext,
   output logic ptrWrite,
   // External SRAM strobes.
   output logic readStrobePin,
   output logic writeStrobePin,
   // EEPROM requests and status.
   input wire logic eeRead,
   input wire logic eeWrite,
   input wire logic [11:0] eeAddr,
   output logic [11:0] eeAddrOut,
   output logic eeWriteDone,
   // Sleep.
   input wire logic deepSleepReq,
   output logic oscKeepOn
);
   import dsd_pkg::*;
   // All checks below sample on the rising clock and pause in reset.
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);
   typedef enum logic [2:0] {
      DSD_IDLE = 3'h1,
      DSD_BUSY = 3'h2,
      DSD_EESTALL = 3'h4
   } dsd_state_t;
   dsd_state_t state_q;
   logic [3:0] cnt_q;
   logic [2:0] eeCnt_q;
   logic ext_q;
   logic wr_q;
   logic [15:0] effAddr_q;
   logic [15:0] ptrNext_q;
   logic ptrWrite_q;
   logic accessDone_q;
   logic fault_q;
   logic oscKeep_q;
   logic [11:0] eeAddr_q;
   logic [15:0] addrD;
   logic [15:0] ptrD;
   dsd_region_t regionD;
   dsd_region_t region_q;
   logic eeBusy;
   logic reqTake;

   // Extra external cycles for a given wait state count.
   function automatic logic [3:0] extraCycles(input logic [1:0] ws,
                                              input logic pc);
      logic [3:0] w;
      w = {2'h0, ws};
      // wait states scale the extra cost
      if (pc) begin
         extraCycles = `DSD_STACK_BASE_EXTRA + (w << 1);
      end else begin
         extraCycles = `DSD_EXT_BASE_EXTRA + w;
      end
   endfunction : extraCycles

   // Effective address and pointer update by addressing mode.
   always_comb begin
      addrD = req.base;
      ptrD = req.base;
      unique case (req.mode)
         DSD_AM_DISP: addrD = req.base + {10'h000, req.disp};
         DSD_AM_PREDEC: begin
            addrD = req.base - 16'h0001;
            ptrD = addrD;
         end
         DSD_AM_POSTINC: ptrD = req.base + 16'h0001;
         DSD_AM_DIRECT: addrD = req.base;
      endcase
   end

   dsd_region_decode u_dec (
      .addr(addrD),
      .legacyMode(legacyMode),
      .region(regionD)
   );

   dsd_ee_timer #(.WRITE_CYCLES(WRITE_CYCLES)) u_ee (
      .sys_clk(sys_clk),
      .startWrite(eeWrite && state_q == DSD_IDLE),
      .busy(eeBusy),
      .done(eeWriteDone)
   );

   assign reqTake = req.valid && state_q == DSD_IDLE && !eeRead && !eeWrite;
   assign reqReady = state_q == DSD_IDLE;
   assign cpuStall = state_q != DSD_IDLE;

   // Access sequencer; internal takes two cycles, external adds waits.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= DSD_IDLE;
         cnt_q <= 4'h0;
         eeCnt_q <= 3'h0;
         ext_q <= 1'b0;
         wr_q <= 1'b0;
      end else begin
         unique case (state_q)
            DSD_IDLE: begin
               if (eeRead) begin
                  state_q <= DSD_EESTALL;
                  eeCnt_q <= `DSD_EE_RD_STALL - 3'h1;
               end else if (eeWrite) begin
                  state_q <= DSD_EESTALL;
                  eeCnt_q <= `DSD_EE_WR_STALL - 3'h1;
               end else if (reqTake) begin
                  state_q <= DSD_BUSY;
                  wr_q <= req.write;
                  ext_q <= regionD == DSD_EXT_SRAM && extSramEnableBit;
                  if (regionD == DSD_EXT_SRAM && extSramEnableBit) begin
                     cnt_q <= `DSD_INT_CYCLES - 4'h2
                              + extraCycles(waitStates, req.pcXfer);
                  end else begin
                     cnt_q <= `DSD_INT_CYCLES - 4'h2;
                  end
               end
            end
            DSD_BUSY: begin
               if (cnt_q == 4'h0) begin
                  state_q <= DSD_IDLE;
                  ext_q <= 1'b0;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            DSD_EESTALL: begin
               if (eeCnt_q == 3'h0) begin
                  state_q <= DSD_IDLE;
               end else begin
                  eeCnt_q <= eeCnt_q - 3'h1;
               end
            end
         endcase
      end
   end

   // Captured address, pointer write-back and fault flag.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         effAddr_q <= 16'h0000;
         ptrNext_q <= 16'h0000;
         ptrWrite_q <= 1'b0;
         fault_q <= 1'b0;
         eeAddr_q <= 12'h000;
      end else begin
         ptrWrite_q <= reqTake && (req.mode == DSD_AM_PREDEC
                                   || req.mode == DSD_AM_POSTINC);
         if (reqTake) begin
            effAddr_q <= addrD;
            ptrNext_q <= ptrD;
            // short I/O ops on extended I/O and disabled external fault
            fault_q <= (req.ioPortOp && regionD == DSD_EXT_IO)
                       || (regionD == DSD_EXT_SRAM && !extSramEnableBit);
         end
         if ((eeRead || eeWrite) && state_q == DSD_IDLE) begin
            eeAddr_q <= eeAddr;
         end
      end
   end

   // Completion pulse in the cycle after the final access cycle.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         accessDone_q <= 1'b0;
      end else begin
         accessDone_q <= state_q == DSD_BUSY && cnt_q == 4'h0;
      end
   end

   // Oscillator stays on once deep sleep overlaps a write.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         oscKeep_q <= 1'b0;
      end else if (!deepSleepReq) begin
         oscKeep_q <= 1'b0;
      end else if (eeBusy) begin
         oscKeep_q <= 1'b1;
      end
   end

   // Region is registered every cycle, not only at take like effAddr; the decode itself
   // stays combinational so the sequencer sees it in the take cycle.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         region_q <= DSD_REG_FILE;
      end else begin
         region_q <= regionD;
      end
   end

   assign readStrobePin = state_q == DSD_BUSY && ext_q && !wr_q;
   assign writeStrobePin = state_q == DSD_BUSY && ext_q && wr_q;
   assign effAddr = effAddr_q;
   assign ptrNext = ptrNext_q;
   assign ptrWrite = ptrWrite_q;
   assign accessDone = accessDone_q;
   assign accessFault = fault_q;
   assign region = region_q;
   assign eeAddrOut = eeAddr_q;
   assign oscKeepOn = oscKeep_q || (deepSleepReq && eeBusy);

   // Stall runs of fixed length, each closed by the stall dropping.
   sequence stall2_s;
      cpuStall [*2] ##1 !cpuStall;
   endsequence : stall2_s
   sequence stall3_s;
      cpuStall [*3] ##1 !cpuStall;
   endsequence : stall3_s
   sequence stall4_s;
      cpuStall [*4] ##1 !cpuStall;
   endsequence : stall4_s
   sequence stall6_s;
      cpuStall [*6] ##1 !cpuStall;
   endsequence : stall6_s
   // The done pulse is registered, so it trails the last busy cycle.
   sequence doneInt_s;
      !accessDone ##1 accessDone;
   endsequence : doneInt_s
   sequence doneExt_s;
      !accessDone [*2] ##1 accessDone;
   endsequence : doneExt_s

   // Strobe only for an enabled access above internal memory.
   // strobe check
   strobe_internal_a: assert property (
      (readStrobePin || writeStrobePin) |-> extSramEnableBit
      && effAddr >= (legacyMode ? `DSD_INT_END_LEGACY : `DSD_INT_END_NORMAL))
      else $error("strobe during internal access");
   ee_read_stall_a: assert property (
      (eeRead && state_q == DSD_IDLE) |=> stall4_s)
      else $error("eeprom read stall wrong");
   ee_write_stall_a: assert property (
      (eeWrite && !eeRead && state_q == DSD_IDLE) |=> stall2_s)
      else $error("eeprom write stall wrong");
   int_two_cycle_a: assert property (
      (reqTake && regionD != DSD_EXT_SRAM) |=> doneInt_s)
      else $error("internal access length wrong");
   ext_extra_a: assert property (
      (reqTake && regionD == DSD_EXT_SRAM && extSramEnableBit
       && waitStates == 2'h0 && !req.pcXfer) |=> doneExt_s)
      else $error("external access length wrong");
   ext_wait_a: assert property (
      (reqTake && regionD == DSD_EXT_SRAM && extSramEnableBit
       && waitStates == 2'h1 && !req.pcXfer) |=> stall3_s)
      else $error("wait state access length wrong");
   ext_stack_a: assert property (
      (reqTake && regionD == DSD_EXT_SRAM && extSramEnableBit
       && waitStates == 2'h0 && req.pcXfer) |=> stall4_s)
      else $error("stack transfer length wrong");
   stack_wait_a: assert property (
      (reqTake && regionD == DSD_EXT_SRAM && extSramEnableBit
       && waitStates == 2'h1 && req.pcXfer) |=> stall6_s)
      else $error("stack wait transfer length wrong");
   legacy_no_extio_a: assert property (
      legacyMode |-> regionD != DSD_EXT_IO)
      else $error("extended io in legacy mode");
   above_int_a: assert property (
      (addrD >= `DSD_INT_END_NORMAL) |-> regionD == DSD_EXT_SRAM)
      else $error("high address not external");
   ext_disabled_a: assert property (
      (reqTake && !extSramEnableBit) |=> !readStrobePin && !writeStrobePin)
      else $error("strobe while external disabled");
   osc_hold_a: assert property (
      (deepSleepReq && eeBusy) |-> oscKeepOn)
      else $error("oscillator released during write");
   osc_sticky_a: assert property (
      (deepSleepReq && oscKeepOn) |=> !deepSleepReq || oscKeepOn)
      else $error("oscillator dropped while asleep");
   predec_ptr_a: assert property (
      (reqTake && req.mode == DSD_AM_PREDEC) |=> ptrWrite
      && ptrNext == effAddr && effAddr == $past(req.base) - 16'h0001)
      else $error("pre-decrement address wrong");
   disp_addr_a: assert property (
      (reqTake && req.mode == DSD_AM_DISP)
      |=> effAddr == $past(req.base) + {10'h000, $past(req.disp)})
      else $error("displacement address wrong");
endmodule : data_space_decoder

// [rtl/dsd_regs.svh]
// Address map, timing and field constants for the data space decoder.
`ifndef DSD_REGS_SVH
`define DSD_REGS_SVH
`define DSD_REGFILE_END 16'h0020
`define DSD_STDIO_END 16'h0060
`define DSD_EXTIO_END 16'h0100
`define DSD_INT_END_NORMAL 16'h1100
`define DSD_INT_END_LEGACY 16'h1000
`define DSD_DISP_MAX 6'h3F
`define DSD_EE_RD_STALL 3'h4
`define DSD_EE_WR_STALL 3'h2
`define DSD_INT_CYCLES 4'h2
`define DSD_EXT_BASE_EXTRA 4'h1
`define DSD_STACK_BASE_EXTRA 4'h3
`define DSD_EE_WRITE_NS 8500000
`define DSD_CLK_NS 10
`endif

// [rtl/dsd_pkg.sv]
// Types shared by the data space decoder modules.
package dsd_pkg;
   typedef enum logic [4:0] {
      DSD_REG_FILE = 5'h01,
      DSD_STD_IO = 5'h02,
      DSD_EXT_IO = 5'h04,
      DSD_INT_SRAM = 5'h08,
      DSD_EXT_SRAM = 5'h10
   } dsd_region_t;
   typedef enum logic [1:0] {
      DSD_AM_DIRECT = 2'h0,
      DSD_AM_DISP = 2'h1,
      DSD_AM_PREDEC = 2'h2,
      DSD_AM_POSTINC = 2'h3
   } dsd_amode_t;
   // One data access request from the load/store unit.
   typedef struct packed {
      logic valid;
      logic write;
      logic isStack;
      logic pcXfer;
      logic ioPortOp;
      dsd_amode_t mode;
      logic [15:0] base;
      logic [5:0] disp;
      logic [7:0] wdata;
   } dsd_req_t;
endpackage : dsd_pkg

// [rtl/dsd_region_decode.sv]
// Combinational region decode of a 16-bit data address.
`timescale 1ns/1ns
`include "dsd_regs.svh"
module dsd_region_decode (
   // Address and layout mode.
   input wire logic [15:0] addr,
   input wire logic legacyMode,
   // Decoded region.
   output dsd_pkg::dsd_region_t region
);
   import dsd_pkg::*;
   logic [15:0] intEnd;
   assign intEnd = legacyMode ? `DSD_INT_END_LEGACY : `DSD_INT_END_NORMAL;
   always_comb begin
      if (addr < `DSD_REGFILE_END) begin
         region = DSD_REG_FILE;
      end else if (addr < `DSD_STDIO_END) begin
         region = DSD_STD_IO;
      // extended I/O only in normal mode
      end else if (!legacyMode && addr < `DSD_EXTIO_END) begin
         region = DSD_EXT_IO;
      end else if (addr < intEnd) begin
         region = DSD_INT_SRAM;
      end else begin
         region = DSD_EXT_SRAM;
      end
   end
endmodule : dsd_region_decode

// [rtl/dsd_ee_timer.sv]
// Self-timed EEPROM write timer with completion flag.
`timescale 1ns/1ns
`include "dsd_regs.svh"
module dsd_ee_timer #(
   parameter int WRITE_CYCLES = `DSD_EE_WRITE_NS / `DSD_CLK_NS
) (
   // Clock only; reset is deliberately not connected here.
   input wire logic sys_clk,
   // Start and status.
   input wire logic startWrite,
   output logic busy,
   output logic done
);
   logic [23:0] cnt_q;
   logic busy_q = 1'b0;
   initial begin
      if (WRITE_CYCLES < 2 || WRITE_CYCLES > 24'hFF_FFFF) begin
         $error("WRITE_CYCLES out of range");
      end
   end
   always_ff @(posedge sys_clk) begin
      if (startWrite && !busy_q) begin
         busy_q <= 1'b1;
         cnt_q <= 24'(WRITE_CYCLES - 1);
      end else if (busy_q) begin
         if (cnt_q == 24'h00_0000) begin
            busy_q <= 1'b0;
         end else begin
            cnt_q <= cnt_q - 24'h00_0001;
         end
      end
   end
   assign busy = busy_q;
   assign done = !busy_q;
endmodule : dsd_ee_timer

// [tb/dsd_strobe_mon.sv]
// External SRAM stand-in that tallies strobe cycles.
`timescale 1ns/1ns
module dsd_strobe_mon (
   // Clock and tally clear.
   input wire logic sys_clk,
   input wire logic clr,
   // Strobes from the decoder.
   input wire logic readStrobePin,
   input wire logic writeStrobePin,
   // Observed figures.
   output int strobeCycles,
   output logic bothSeen
);
   // No wait of its own, so every strobe cycle is the decoder's choice.
   always_ff @(posedge sys_clk) begin
      if (clr) begin
         strobeCycles <= 0;
         bothSeen <= 1'b0;
      end else begin
         if (readStrobePin || writeStrobePin) strobeCycles <= strobeCycles + 1;
         if (readStrobePin && writeStrobePin) bothSeen <= 1'b1;
      end
   end
endmodule : dsd_strobe_mon

// [tb/tb_data_space_decoder.sv]
// Self-checking bench for the data space decoder.
`timescale 1ns/1ns
module tb_data_space_decoder;
   import dsd_pkg::*;
   logic sys_clk = 1'b0, arst_n = 1'b0, legacyMode = 1'b0, clr = 1'b1;
   logic extSramEnableBit = 1'b1, eeRead = 1'b0, eeWrite = 1'b0;
   logic deepSleepReq = 1'b0, reqReady, cpuStall, accessDone, accessFault;
   logic ptrWrite, readStrobePin, writeStrobePin, eeWriteDone, oscKeepOn;
   logic bothSeen;
   logic [1:0] waitStates = 2'h0;
   logic [11:0] eeAddr = 12'h000, eeAddrOut;
   logic [15:0] effAddr, ptrNext;
   dsd_req_t req = '0;
   dsd_region_t region;
   int strobeCycles, n_fail = 0, n_tests = 0;
   data_space_decoder #(.WRITE_CYCLES(20)) u_data_space_decoder (
      .sys_clk(sys_clk), .arst_n(arst_n), .legacyMode(legacyMode),
      .extSramEnableBit(extSramEnableBit), .waitStates(waitStates),
      .req(req), .reqReady(reqReady), .cpuStall(cpuStall),
      .accessDone(accessDone), .effAddr(effAddr), .region(region),
      .accessFault(accessFault), .ptrNext(ptrNext), .ptrWrite(ptrWrite),
      .readStrobePin(readStrobePin), .writeStrobePin(writeStrobePin),
      .eeRead(eeRead), .eeWrite(eeWrite), .eeAddr(eeAddr),
      .eeAddrOut(eeAddrOut), .eeWriteDone(eeWriteDone),
      .deepSleepReq(deepSleepReq), .oscKeepOn(oscKeepOn));
   dsd_strobe_mon u_dsd_strobe_mon (.sys_clk(sys_clk), .clr(clr),
      .readStrobePin(readStrobePin), .writeStrobePin(writeStrobePin),
      .strobeCycles(strobeCycles), .bothSeen(bothSeen));
   // Free-running 100 MHz clock.
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [31:0] seen, exp, input string msg);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim
   // Expected region from the layout boundaries of each mode.
   function automatic logic [4:0] exp_region(input int a, input logic leg);
      if (a < 32) return 5'h01;
      if (a < 96) return 5'h02;
      if (a < 256 && !leg) return 5'h04;
      if (a < (leg ? 4096 : 4352)) return 5'h08;
      return 5'h10;
   endfunction : exp_region
   // One load/store; tallies stall cycles and the cycle of completion.
   task automatic access(input logic [15:0] a, input logic pcx, io,
         input dsd_amode_t m, input logic [5:0] d, output int stall, doneAt,
         output logic pw);
      stall = 0;
      doneAt = 0;
      pw = 1'b0;
      clr = 1'b1;
      req = '{1'b1, pcx, pcx, pcx, io, m, a, d, 8'h5A};
      @(negedge sys_clk);
      clr = 1'b0;
      req.valid = 1'b0;
      for (int k = 1; k <= 30; k++) begin
         if (cpuStall === 1'b1) stall++;
         if (accessDone === 1'b1) doneAt = k;
         if (ptrWrite === 1'b1) pw = 1'b1;
         @(negedge sys_clk);
      end
   endtask : access
   // One EEPROM request pulse; returns the stall length.
   task automatic ee_op(input logic wr, output int stall);
      stall = 0;
      eeAddr = 12'hABC;
      eeRead = !wr;
      eeWrite = wr;
      @(negedge sys_clk);
      eeRead = 1'b0;
      eeWrite = 1'b0;
      for (int k = 0; k < 8; k++) begin
         if (cpuStall === 1'b1) stall++;
         @(negedge sys_clk);
      end
   endtask : ee_op
   task automatic wait_done();
      int k = 0;
      while (eeWriteDone !== 1'b1 && k < 40) begin
         @(negedge sys_clk);
         k++;
      end
      check(k < 40, 1'b1, "write completion");
   endtask : wait_done
   // Region boundaries in both layout modes.
   task automatic t_map();
      int adr [9] = '{0, 31, 32, 95, 96, 255, 256, 4095, 4351};
      for (int l = 0; l < 2; l++) begin
         legacyMode = l[0];
         for (int i = 0; i < 11; i++) begin
            req.base = (i < 9) ? adr[i] : ((i == 9) ? 16'h1100 : 16'hFFFF);
            @(negedge sys_clk);
            check(region, exp_region(req.base, l[0]), "region");
            check(region, exp_region(req.base, l[0]), "boundary");
         end
      end
      legacyMode = 1'b0;
   endtask : t_map
   // Internal cycle count, then external cycle counts for every wait-state setting.
   task automatic t_timing();
      int s, d;
      logic p;
      access(16'h0200, 1'b0, 1'b0, DSD_AM_DIRECT, 6'h00, s, d, p);
      check(d, 2, "internal done");
      check(strobeCycles, 0, "internal strobes");
      for (int w = 0; w < 4; w++) begin
         waitStates = w[1:0];
         access(16'h2000, 1'b0, 1'b0, DSD_AM_DIRECT, 6'h00, s, d, p);
         check(s, 2 + w, "byte stall");
         check(d, 3 + w, "byte done");
         check(strobeCycles, 2 + w, "byte strobes");
         access(16'hFF00, 1'b1, 1'b0, DSD_AM_DIRECT, 6'h00, s, d, p);
         check(s, 4 + 2 * w, "stack stall");
         check(bothSeen, 1'b0, "strobe overlap");
      end
      waitStates = 2'h0;
   endtask : t_timing
   // Disabled external memory and short I/O ops on extended I/O.
   task automatic t_fault();
      int s, d;
      logic p;
      extSramEnableBit = 1'b0;
      access(16'h2000, 1'b0, 1'b0, DSD_AM_DIRECT, 6'h00, s, d, p);
      check(accessFault, 1'b1, "disabled fault");
      check(strobeCycles, 0, "disabled strobes");
      extSramEnableBit = 1'b1;
      access(16'h0080, 1'b0, 1'b1, DSD_AM_DIRECT, 6'h00, s, d, p);
      check(accessFault, 1'b1, "io op ext");
      access(16'h0040, 1'b0, 1'b1, DSD_AM_DIRECT, 6'h00, s, d, p);
      check(accessFault, 1'b0, "io op std");
   endtask : t_fault
   // Displacement and pointer update modes.
   task automatic t_ptr();
      int s, d;
      logic p;
      access(16'h0100, 1'b0, 1'b0, DSD_AM_DISP, 6'h3F, s, d, p);
      check(effAddr, 16'h013F, "disp addr");
      access(16'h0201, 1'b0, 1'b0, DSD_AM_PREDEC, 6'h00, s, d, p);
      check(effAddr, 16'h0200, "predec addr");
      check({p, ptrNext}, 17'h1_0200, "predec ptr");
      access(16'h0300, 1'b0, 1'b0, DSD_AM_POSTINC, 6'h00, s, d, p);
      check(effAddr, 16'h0300, "postinc addr");
      check({p, ptrNext}, 17'h1_0301, "postinc ptr");
   endtask : t_ptr
   // EEPROM stalls, self-timed write, reset and sleep during a write.
   task automatic t_ee();
      int s;
      ee_op(1'b0, s);
      check(s, 4, "ee read stall");
      check(eeAddrOut, 12'hABC, "ee addr");
      ee_op(1'b1, s);
      check(s, 2, "ee write stall");
      check(eeWriteDone, 1'b0, "write busy");
      ee_op(1'b1, s);
      check(s, 2, "busy write stall");
      wait_done();
      ee_op(1'b1, s);
      arst_n = 1'b0;
      @(negedge sys_clk);
      arst_n = 1'b1;
      check(eeWriteDone, 1'b0, "write kept");
      wait_done();
      ee_op(1'b1, s);
      deepSleepReq = 1'b1;
      @(negedge sys_clk);
      check(oscKeepOn, 1'b1, "osc during write");
      wait_done();
      @(negedge sys_clk);
      check(oscKeepOn, 1'b1, "osc after write");
      deepSleepReq = 1'b0;
   endtask : t_ee
   // Main sequence.
   initial begin
      repeat (3) @(negedge sys_clk);
      arst_n = 1'b1;
      @(negedge sys_clk);
      check(reqReady, 1'b1, "idle ready");
      t_map();
      t_timing();
      t_fault();
      t_ptr();
      t_ee();
      end_sim();
   end
   // Watchdog sized well above the few hundred cycles the tests take.
   initial begin
      #200000;
      n_fail++;
      end_sim();
   end
endmodule : tb_data_space_decoder
